// *** rtl/remote_onoff_status_contacts.sv ***
// Remote start/stop, status flags and programmable relay contacts
`timescale 1ns/100ps
`include "onoff_map.svh"
module remote_onoff_status_contacts
  import onoff_pkg::*;
#(
  parameter int HOLD_CYCLES = `HOLD_CYCLES,
  parameter int BLINK_CYCLES = `BLINK_CYCLES
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic emergency_shutoff_input,
  input wire logic onoff_contact,
  input wire logic panel_onoff_key,
  input wire logic panel_reset_key,
  input wire logic load_over_capacity,
  input wire logic fault_detected,
  input wire logic dc_link_abnormal,
  output logic filter_run,
  output logic compensating_indicator,
  output logic compensating_status,
  output logic current_limit_status,
  output logic fault_status,
  output logic dc_link_fault_status,
  output logic par_alarm,
  output logic buzzer,
  output logic powered_contact,
  output logic compensating_contact,
  output logic current_limit_contact,
  output logic fault_contact,
  output logic dc_link_fault_contact,
  output logic irq
);

  localparam int BW = $clog2(BLINK_CYCLES + 1);

  generate
    if (BLINK_CYCLES < 2) begin : g_check
      $error("BLINK_CYCLES must be at least 2");
    end
  endgenerate

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  state_type state;
  state_type next_state;
  logic level_mode;
  logic next_level_mode;
  logic [14:0] contact_sel;
  logic [14:0] next_contact_sel;
  logic [7:0] par_cfg;
  logic [7:0] next_par_cfg;
  logic [`IRQ_WIDTH-1:0] irq_status;
  logic [`IRQ_WIDTH-1:0] next_irq_status;
  logic [`IRQ_WIDTH-1:0] irq_mask;
  logic [`IRQ_WIDTH-1:0] next_irq_mask;
  logic [`IRQ_WIDTH-1:0] events;
  logic [31:0] next_rdata;
  logic next_fault;
  logic next_buzzer;
  logic next_dc_link;
  logic prev_par_bad;
  logic par_bad;
  logic start_ok;
  logic contact_level;
  logic contact_rise;
  logic contact_fall;
  logic [BW-1:0] blink_cnt;
  logic [BW-1:0] next_blink_cnt;
  logic blink;
  logic next_blink;
  logic [7:0] src;
  logic [4:0] contacts;
  logic [4:0] next_contacts;
  logic ctrl_written;
  logic [3:0] par_count;
  logic [3:0] par_index;

  contact_qualifier #(
    .QUAL_CYCLES(HOLD_CYCLES)
  ) u_qual (
    .core_clk(core_clk),
    .resetn(resetn),
    .raw(onoff_contact),
    .level(contact_level),
    .rise(contact_rise),
    .fall(contact_fall)
  );

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  always_comb begin
    next_level_mode = level_mode;
    next_contact_sel = contact_sel;
    next_par_cfg = par_cfg;
    next_irq_mask = irq_mask;
    next_rdata = 32'h0000_0000;
    if (wr) begin
      case (addr)
        `REG_CTRL: next_level_mode = wdata[`CTRL_MODE_BIT];
        `REG_CONTACT_SEL: next_contact_sel = wdata[14:0];
        `REG_PAR_CFG: next_par_cfg = wdata[7:0];
        `REG_IRQ_MASK: next_irq_mask = wdata[`IRQ_WIDTH-1:0];
        default: ;
      endcase
    end
    if (rd) begin
      case (addr)
        `REG_CTRL: next_rdata = {31'h0000_0000, level_mode};
        `REG_CONTACT_SEL: next_rdata = {17'h0_0000, contact_sel};
        `REG_PAR_CFG: next_rdata = {24'h00_0000, par_cfg};
        `REG_STATUS: next_rdata = {23'h00_0000, contact_level,
          emergency_shutoff_input, buzzer, par_alarm, dc_link_fault_status,
          fault_status, current_limit_status, state == ST_STANDBY, state == ST_RUN};
        `REG_IRQ_STATUS: next_rdata = {27'h000_0000, irq_status};
        `REG_IRQ_MASK: next_rdata = {27'h000_0000, irq_mask};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      level_mode <= 1'b0;
      contact_sel <= `CONTACT_SEL_RESET;
      par_cfg <= `PAR_CFG_RESET;
      irq_mask <= '0;
      rdata <= 32'h0000_0000;
    end else begin
      level_mode <= next_level_mode;
      contact_sel <= next_contact_sel;
      par_cfg <= next_par_cfg;
      irq_mask <= next_irq_mask;
      rdata <= next_rdata;
    end
  end

  // ----------------------------------------
  // Parallel settings check
  // ----------------------------------------
  assign par_count = par_cfg[`PAR_COUNT_LSB +: `PAR_FIELD_WIDTH];
  assign par_index = par_cfg[`PAR_INDEX_LSB +: `PAR_FIELD_WIDTH];
  assign par_bad = (par_count == 4'h0) || (par_count > `PAR_MAX_MODULES) ||
    (par_index >= par_count);
  assign start_ok = !par_bad && !fault_status && !emergency_shutoff_input;

  // ----------------------------------------
  // Run state
  // ----------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_STOP: begin
        if (start_ok && panel_onoff_key) begin
          if (!level_mode) begin
            next_state = ST_RUN;
          end else if (contact_level) begin
            next_state = ST_STANDBY;
          end
        end else if (start_ok && !level_mode && contact_rise) begin
          next_state = ST_RUN;
        end
      end
      ST_STANDBY: begin
        if (panel_onoff_key || !level_mode) begin
          next_state = ST_STOP;
        end else if (start_ok && contact_rise) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (panel_onoff_key) begin
          next_state = ST_STOP;
        end else if (!level_mode && contact_rise) begin
          next_state = ST_STOP;
        end else if (level_mode && contact_fall) begin
          next_state = ST_STANDBY;
        end
      end
      default: next_state = ST_STOP;
    endcase
    if (emergency_shutoff_input || next_fault || par_bad) begin
      next_state = ST_STOP;
    end
  end

  always_comb begin
    next_fault = fault_status;
    next_buzzer = buzzer;
    if (panel_reset_key) begin
      next_fault = 1'b0;
      next_buzzer = 1'b0;
    end
    if (fault_detected) begin
      next_fault = 1'b1;
      next_buzzer = 1'b1;
    end
    if (par_bad && !prev_par_bad) begin
      next_buzzer = 1'b1;
    end
    next_dc_link = dc_link_abnormal;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_STOP;
      fault_status <= 1'b0;
      buzzer <= 1'b0;
      dc_link_fault_status <= 1'b0;
      prev_par_bad <= 1'b0;
    end else begin
      state <= next_state;
      fault_status <= next_fault;
      buzzer <= next_buzzer;
      dc_link_fault_status <= next_dc_link;
      prev_par_bad <= par_bad;
    end
  end

  assign filter_run = (state == ST_RUN) && !emergency_shutoff_input;
  assign compensating_status = filter_run;
  assign current_limit_status = filter_run && load_over_capacity;
  assign par_alarm = par_bad;

  // ----------------------------------------
  // Standby blink and contacts
  // ----------------------------------------
  always_comb begin
    next_blink_cnt = blink_cnt + BW'(1);
    next_blink = blink;
    if (state != ST_STANDBY) begin
      next_blink_cnt = '0;
      next_blink = 1'b0;
    end else if (blink_cnt == BW'(BLINK_CYCLES - 1)) begin
      next_blink_cnt = '0;
      next_blink = ~blink;
    end
  end

  assign src = {1'b0, state == ST_STANDBY, par_bad, dc_link_fault_status,
    fault_status, current_limit_status, compensating_status, 1'b1};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_contact
      assign next_contacts[gi] = src[contact_sel[gi*`SEL_WIDTH +: `SEL_WIDTH]];
    end
  endgenerate

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      blink_cnt <= '0;
      blink <= 1'b0;
      contacts <= '0;
    end else begin
      blink_cnt <= next_blink_cnt;
      blink <= next_blink;
      contacts <= next_contacts;
    end
  end

  assign compensating_indicator = filter_run || blink;
  assign powered_contact = contacts[0];
  assign compensating_contact = contacts[1];
  assign current_limit_contact = contacts[2];
  assign fault_contact = contacts[3];
  assign dc_link_fault_contact = contacts[4];

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  assign events[`IRQ_RUN_START] = (next_state == ST_RUN) && (state != ST_RUN);
  assign events[`IRQ_RUN_STOP] = (next_state != ST_RUN) && (state == ST_RUN);
  assign events[`IRQ_FAULT] = fault_detected && !fault_status;
  assign events[`IRQ_SHUTOFF] = emergency_shutoff_input;
  assign events[`IRQ_PAR_ALARM] = par_bad && !prev_par_bad;

  always_comb begin
    next_irq_status = irq_status;
    if (rd && addr == `REG_IRQ_STATUS) begin
      next_irq_status = '0;
    end
    next_irq_status = next_irq_status | events;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irq_status <= '0;
      ctrl_written <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      ctrl_written <= ctrl_written || (wr && addr == `REG_CTRL);
    end
  end

  assign irq = |(irq_status & irq_mask);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_level_start;
    level_mode && (state == ST_STANDBY) && contact_rise && start_ok && !panel_onoff_key &&
      !fault_detected;
  endsequence

  sequence s_level_stop;
    level_mode && (state == ST_RUN) && contact_fall && !panel_onoff_key;
  endsequence

  AST_SHUTOFF_STOP: assert property (@(posedge core_clk) disable iff (!resetn)
    emergency_shutoff_input |-> !filter_run ##1 (state == ST_STOP))
    else $error("Filter ran during emergency shutoff");

  AST_DEFAULT_MODE: assert property (@(posedge core_clk) disable iff (!resetn)
    !ctrl_written |-> !level_mode)
    else $error("Level mode without a control write");

  AST_TOGGLE: assert property (@(posedge core_clk) disable iff (!resetn)
    (!level_mode && contact_rise && !panel_onoff_key && !fault_detected && start_ok &&
      (state == ST_STOP)) |=> (state == ST_RUN))
    else $error("Toggle press did not start the filter");

  AST_LEVEL_START: assert property (@(posedge core_clk) disable iff (!resetn)
    s_level_start |=> (state == ST_RUN))
    else $error("Level contact did not start the filter");

  AST_LEVEL_STOP: assert property (@(posedge core_clk) disable iff (!resetn)
    s_level_stop |=> (state != ST_RUN))
    else $error("Level contact did not stop the filter");

  AST_STANDBY: assert property (@(posedge core_clk) disable iff (!resetn)
    (level_mode && (state == ST_STOP) && panel_onoff_key && contact_level && start_ok &&
      !fault_detected) |=> (state == ST_STANDBY))
    else $error("Panel key in level mode did not enter standby");

  AST_CONTACT_MAP: assert property (@(posedge core_clk) disable iff (!resetn)
    (contact_sel == `CONTACT_SEL_RESET) |=> (powered_contact == 1'b1))
    else $error("Default powered contact not set");

  AST_CURRENT_LIMIT: assert property (@(posedge core_clk) disable iff (!resetn)
    ((state == ST_RUN) && load_over_capacity && !emergency_shutoff_input &&
      !panel_onoff_key && !contact_rise && !contact_fall && !fault_detected && !par_bad)
      |-> current_limit_status ##1 (state == ST_RUN))
    else $error("Current limit stopped the filter");

  AST_FAULT_STOP: assert property (@(posedge core_clk) disable iff (!resetn)
    fault_detected |=> fault_status && (state == ST_STOP))
    else $error("Fault did not latch and stop");

  AST_PAR_BLOCK: assert property (@(posedge core_clk) disable iff (!resetn)
    par_bad |=> (state != ST_RUN) || !$past(par_bad))
    else $error("Filter ran with bad parallel settings");

  AST_RESET_KEY: assert property (@(posedge core_clk) disable iff (!resetn)
    (panel_reset_key && !fault_detected) |=> !fault_status && !buzzer)
    else $error("Reset key did not clear fault and alarm");

endmodule

// *** rtl/onoff_map.svh ***
// Offsets, fields, reset values and timing counts of the on/off and contact block
`ifndef ONOFF_MAP_SVH
`define ONOFF_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define REG_CTRL 8'h00
`define REG_CONTACT_SEL 8'h04
`define REG_PAR_CFG 8'h08
`define REG_STATUS 8'h0C
`define REG_IRQ_STATUS 8'h10
`define REG_IRQ_MASK 8'h14

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define CTRL_MODE_BIT 0
`define SEL_WIDTH 3
`define CONTACT_SEL_RESET 15'h4688
`define PAR_COUNT_LSB 0
`define PAR_INDEX_LSB 4
`define PAR_FIELD_WIDTH 4
`define PAR_CFG_RESET 8'h01
`define PAR_MAX_MODULES 4'h8
`define IRQ_WIDTH 5
`define IRQ_RUN_START 0
`define IRQ_RUN_STOP 1
`define IRQ_FAULT 2
`define IRQ_SHUTOFF 3
`define IRQ_PAR_ALARM 4

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_FREQ_KHZ 10000
`define HOLD_TIME_MS 2000
`define BLINK_TIME_MS 500
`define HOLD_CYCLES (`HOLD_TIME_MS * `CLK_FREQ_KHZ)
`define BLINK_CYCLES (`BLINK_TIME_MS * `CLK_FREQ_KHZ)

`endif

// *** rtl/onoff_pkg.sv ***
// Types shared by the on/off and contact block
package onoff_pkg;

  typedef enum logic [2:0] {
    ST_STOP = 3'b001,
    ST_STANDBY = 3'b010,
    ST_RUN = 3'b100
  } state_type;

  typedef enum logic [2:0] {
    SRC_POWERED = 3'h0,
    SRC_COMPENSATING = 3'h1,
    SRC_CURRENT_LIMIT = 3'h2,
    SRC_FAULT = 3'h3,
    SRC_DC_LINK = 3'h4,
    SRC_PAR_ALARM = 3'h5,
    SRC_STANDBY = 3'h6,
    SRC_NONE = 3'h7
  } src_sel_type;

endpackage

// *** rtl/contact_qualifier.sv ***
// Two-second qualification of the input dry contact
`timescale 1ns/100ps
module contact_qualifier #(
  parameter int QUAL_CYCLES = 20000000
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic raw,
  output logic level,
  output logic rise,
  output logic fall
);

  localparam int CW = $clog2(QUAL_CYCLES + 1);

  generate
    if (QUAL_CYCLES < 2) begin : g_check
      $error("QUAL_CYCLES must be at least 2");
    end
  endgenerate

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic next_level;
  logic next_rise;
  logic next_fall;

  // ----------------------------------------
  // Qualification counter
  // ----------------------------------------
  always_comb begin
    next_cnt = '0;
    next_level = level;
    next_rise = 1'b0;
    next_fall = 1'b0;
    if (raw != level) begin
      if (cnt == CW'(QUAL_CYCLES - 1)) begin
        next_level = raw;
        next_rise = raw;
        next_fall = ~raw;
      end else begin
        next_cnt = cnt + CW'(1);
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= '0;
      level <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      cnt <= next_cnt;
      level <= next_level;
      rise <= next_rise;
      fall <= next_fall;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_BOUNCE_RESTART: assert property (@(posedge core_clk) disable iff (!resetn)
    (raw == level) |=> (cnt == '0))
    else $error("Counter not restarted when contact returned");

endmodule

// *** tb/switch_model.sv ***
// Behavioural external on/off switch with optional contact chatter
`timescale 1ns/100ps
module switch_model (
  input wire logic core_clk,
  input wire logic target,
  input wire logic bounce,
  output logic onoff_contact
);
  integer chat_seed = 5;
  logic [31:0] noise;
  initial onoff_contact = 1'b0;
  // ----------------------------------------
  // Contact follows switch or chatters
  // ----------------------------------------
  always @(posedge core_clk) begin
    noise = $random(chat_seed);
    if (bounce) begin
      onoff_contact <= noise[0];
    end else begin
      onoff_contact <= target;
    end
  end
endmodule

// *** tb/test_remote_onoff_status_contacts.sv ***
// Self-checking bench for the remote on/off and status contact block
`timescale 1ns/100ps
`include "onoff_map.svh"
module test_remote_onoff_status_contacts
  import onoff_pkg::*;
;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic shutoff = 1'b0;
  logic target = 1'b0;
  logic bounce = 1'b0;
  logic onoff_key = 1'b0;
  logic reset_key = 1'b0;
  logic over_cap = 1'b0;
  logic fault_in = 1'b0;
  logic dc_abn = 1'b0;
  logic [31:0] rdata;
  logic contact, filter_run, comp_ind, comp_stat, limit_stat, fault_stat, dc_stat;
  logic par_alarm, buzzer, irq;
  logic [4:0] contacts;
  logic [31:0] rv;
  logic [14:0] sel;
  logic seen0, seen1;
  logic [7:0] bad [3] = '{8'h00, 8'h09, 8'h22};
  integer seed = 77;
  integer n_mismatch = 0;
  integer compares = 0;

  always #50 core_clk = ~core_clk;

  switch_model sw_u (.core_clk(core_clk), .target(target), .bounce(bounce),
    .onoff_contact(contact));

  remote_onoff_status_contacts #(.HOLD_CYCLES(20), .BLINK_CYCLES(4)) dut_u (
    .core_clk(core_clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .emergency_shutoff_input(shutoff), .onoff_contact(contact),
    .panel_onoff_key(onoff_key), .panel_reset_key(reset_key),
    .load_over_capacity(over_cap), .fault_detected(fault_in), .dc_link_abnormal(dc_abn),
    .filter_run(filter_run), .compensating_indicator(comp_ind),
    .compensating_status(comp_stat), .current_limit_status(limit_stat),
    .fault_status(fault_stat), .dc_link_fault_status(dc_stat), .par_alarm(par_alarm),
    .buzzer(buzzer), .powered_contact(contacts[0]), .compensating_contact(contacts[1]),
    .current_limit_contact(contacts[2]), .fault_contact(contacts[3]),
    .dc_link_fault_contact(contacts[4]), .irq(irq));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic key(input logic which);
    @(posedge core_clk);
    onoff_key <= ~which;
    reset_key <= which;
    @(posedge core_clk);
    onoff_key <= 1'b0;
    reset_key <= 1'b0;
    cyc(3);
  endtask
  task automatic drive(input logic lvl, input int n);
    @(posedge core_clk);
    target <= lvl;
    cyc(n);
  endtask
  function automatic logic src_exp(input logic [2:0] code, input logic dc);
    case (code)
      SRC_POWERED: src_exp = 1'b1;
      SRC_DC_LINK: src_exp = dc;
      default: src_exp = 1'b0;
    endcase
  endfunction
  task automatic finish_test();
    if (n_mismatch == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (10000) @(posedge core_clk);
    n_mismatch++;
    finish_test();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    cyc(8);
    resetn <= 1'b1;
    cyc(2);
    chk("powered_contact", 1, contacts[0]);
    rd_reg(`REG_CONTACT_SEL, rv);
    chk("contact_sel", 32'h0000_4688, rv);
    rd_reg(`REG_CTRL, rv);
    chk("ctrl", 32'h0000_0000, rv);
    rd_reg(8'hFC, rv);
    chk("unmapped", 32'h0000_0000, rv);
    bounce <= 1'b1;
    cyc(60);
    bounce <= 1'b0;
    drive(1'b1, 12);
    drive(1'b0, 4);
    drive(1'b1, 12);
    drive(1'b0, 30);
    chk("run_bounce", 0, filter_run);
    wr_reg(`REG_IRQ_MASK, 32'h0000_0001);
    rd_reg(`REG_IRQ_STATUS, rv);
    drive(1'b1, 15);
    chk("run_early", 0, filter_run);
    cyc(15);
    chk("run_toggle_on", 1, filter_run);
    chk("comp_status", 1, comp_stat);
    chk("comp_contact", 1, contacts[1]);
    chk("irq_on", 1, irq);
    rd_reg(`REG_IRQ_STATUS, rv);
    chk("irq_status", 32'h0000_0001, rv);
    chk("irq_cleared", 0, irq);
    drive(1'b0, 30);
    chk("run_open", 1, filter_run);
    drive(1'b1, 30);
    chk("run_toggle_off", 0, filter_run);
    drive(1'b0, 30);
    key(1'b0);
    chk("run_key", 1, filter_run);
    over_cap <= 1'b1;
    cyc(2);
    chk("limit_status", 1, limit_stat);
    chk("run_limit", 1, filter_run);
    chk("limit_contact", 1, contacts[2]);
    rd_reg(`REG_STATUS, rv);
    chk("status", 32'h0000_0005, rv);
    over_cap <= 1'b0;
    shutoff <= 1'b1;
    #1 chk("run_shutoff", 0, filter_run);
    cyc(3);
    shutoff <= 1'b0;
    cyc(3);
    chk("run_after_shutoff", 0, filter_run);
    key(1'b0);
    @(posedge core_clk);
    fault_in <= 1'b1;
    @(posedge core_clk);
    fault_in <= 1'b0;
    cyc(2);
    chk("fault_status", 1, fault_stat);
    chk("run_fault", 0, filter_run);
    chk("fault_contact", 1, contacts[3]);
    chk("buzzer", 1, buzzer);
    key(1'b0);
    chk("run_refused", 0, filter_run);
    key(1'b1);
    chk("fault_clear", 0, fault_stat);
    chk("buzzer_off", 0, buzzer);
    key(1'b0);
    chk("run_restart", 1, filter_run);
    key(1'b0);
    chk("run_stop", 0, filter_run);
    for (int i = 0; i < 3; i++) begin
      wr_reg(`REG_PAR_CFG, {24'h00_0000, bad[i]});
      cyc(1);
      chk("par_alarm", 1, par_alarm);
      key(1'b0);
      chk("run_par", 0, filter_run);
    end
    wr_reg(`REG_PAR_CFG, 32'h0000_0012);
    cyc(1);
    chk("par_ok", 0, par_alarm);
    wr_reg(`REG_CTRL, 32'h0000_0001);
    drive(1'b1, 30);
    key(1'b0);
    chk("run_standby", 0, filter_run);
    seen0 = 1'b0;
    seen1 = 1'b0;
    repeat (12) begin
      @(posedge core_clk);
      #1 seen0 = seen0 | ~comp_ind;
      seen1 = seen1 | comp_ind;
    end
    chk("blink", 2'b11, {seen0, seen1});
    drive(1'b0, 30);
    drive(1'b1, 15);
    chk("level_early", 0, filter_run);
    cyc(15);
    chk("level_on", 1, filter_run);
    drive(1'b0, 15);
    chk("level_hold", 1, filter_run);
    cyc(15);
    chk("level_off", 0, filter_run);
    key(1'b0);
    wr_reg(`REG_CTRL, 32'h0000_0000);
    for (int i = 0; i < 12; i++) begin
      rv = $random(seed);
      sel = (i == 0) ? 15'h7D63 : (i == 1) ? 15'h4688 : rv[14:0];
      rv = $random(seed);
      dc_abn <= rv[0];
      wr_reg(`REG_CONTACT_SEL, {17'h0_0000, sel});
      cyc(4);
      chk("dc_status", dc_abn, dc_stat);
      for (int j = 0; j < 5; j++) begin
        chk("contact", src_exp(sel[3*j+:3], dc_abn), contacts[j]);
      end
    end
    finish_test();
  end
endmodule
